//--- inc/psr_cfg.svh
`ifndef PSR_CFG_SVH
`define PSR_CFG_SVH
// Avalon word offsets (byte address = 4 x index)
`define PSR_IDX_BANK0      9'h003
`define PSR_IDX_BANK1      9'h083
`define PSR_IDX_BANK2      9'h103
`define PSR_IDX_BANK3      9'h183
`define PSR_OFF_FLAGS      11'h00c
`define PSR_OFF_CMD        11'h40c
`define PSR_OFF_OPA        11'h410
`define PSR_OFF_ALU        11'h414
`define PSR_OFF_EVT        11'h418
// Field positions
`define PSR_BIT_C          0
`define PSR_BIT_NCARRY     1
`define PSR_BIT_Z          2
`define PSR_BIT_SLEEP      3
`define PSR_BIT_WDOG       4
`define PSR_BIT_DBANK_LO   5
`define PSR_BIT_DBANK_HI   6
`define PSR_BIT_IBANK      7
// Power-on value, low flags undefined so taken as zero
`define PSR_RESET_VAL      8'h18
`define PSR_FLAG_MASK      8'h07
`define PSR_CAUSE_MASK     8'h18
`endif

//--- inc/psr_pkg.sv
package psr_pkg;
   // Operations the execution datapath applies to the register
   typedef enum logic [2:0] {
      PSR_OP_MOVE,
      PSR_OP_CLEAR,
      PSR_OP_ADD,
      PSR_OP_SUB,
      PSR_OP_LOGIC
   } psr_op_e;
endpackage

//--- design/psr_status_reg.sv
// Local design decision: the Avalon-MM register port.
`timescale 1ns/10ps
`include "psr_cfg.svh"
// Operation
// - Status register accepted as destination of any instruction, like any file register.
// - Flag-updating instructions block data writes to zero, carry, nibble carry bits.
// - Software writes never change watchdog expiry or sleep entered flags.
// - Clear operation zeroes bank bits, sets zero flag, keeps cause and carries.
// - Subtraction carry and nibble carry read as inverted borrow.
// - Subtraction adds two's complement of second operand; flags from that sum.
// - Register decoded at four bank-mirrored addresses, one physical register.
module psr_status_reg (
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        resetn_in,
   // Avalon-MM slave
   input  wire logic [10:0] avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   output logic [1:0]       avs_response_out,
   // Reset-cause events from core logic
   input  wire logic        wdt_timeout_in,
   input  wire logic        sleep_exec_in,
   input  wire logic        wdt_clear_in,
   // Bank selects to address decode
   output logic [1:0]       direct_bank_out,
   output logic             indirect_half_out
);
   // Architectural register and the values that feed it
   logic [7:0]  status;
   logic [7:0]  next_status;
   logic [7:0]  cmd_status;     // Value a command write would leave

   // Arithmetic side registers and datapath
   logic [7:0]  operand_a;
   logic [7:0]  alu_result;
   logic [8:0]  sum;
   logic [4:0]  nib;
   logic [7:0]  b_op;
   logic        sub_mode;
   logic        arith_op;

   // Bus decode and strobes
   logic [7:0]  wr_byte;
   logic        ack;
   logic        cmd_hit;
   logic        flag_hit;
   logic        opa_hit;
   logic        rd_take;
   logic        wr_take;
   logic        flag_wr;
   logic        cmd_wr;
   logic        opa_wr;
   psr_pkg::psr_op_e op;

   // Event pins after the two-stage synchroniser
   logic [2:0]  ev_meta;
   logic [2:0]  ev_sync;
   logic        ev_timeout;
   logic        ev_sleep;
   logic        ev_kick;

   // Registered bank bits, one element per select line
   logic        bank_bit [3];

   // Word index decode; true for any mirror of the status register.
   // A mirror in every bank lets code reach the flags without first
   // switching banks, which would itself need the flags.
   function automatic logic is_status(input logic [10:0] a);
      return (a[1:0] == 2'b00) &&
         ((a[10:2] == `PSR_IDX_BANK0) || (a[10:2] == `PSR_IDX_BANK1) ||
          (a[10:2] == `PSR_IDX_BANK2) || (a[10:2] == `PSR_IDX_BANK3));
   endfunction

   // Exact match of one side register; shared by write and read decode
   function automatic logic word_is(input logic [10:0] a, input logic [10:0] off);
      return (a == off);
   endfunction

   // Keep the bits named in keep and take the rest from the new byte.
   // Every masked write goes through here, so no path can forget the
   // cause bits or let a data byte overwrite a flag it must not touch.
   function automatic logic [7:0] merge_keep(input logic [7:0] old_v,
                                             input logic [7:0] new_v,
                                             input logic [7:0] keep);
      return (old_v & keep) | (new_v & ~keep);
   endfunction

   // Address and data decode
   assign flag_hit = is_status(avs_address_in);
   assign cmd_hit  = word_is(avs_address_in, `PSR_OFF_CMD);
   assign opa_hit  = word_is(avs_address_in, `PSR_OFF_OPA);
   assign wr_byte  = avs_writedata_in[7:0];
   assign op       = psr_pkg::psr_op_e'(avs_writedata_in[10:8]);

   // Reads are sampled at the first edge of a request, so the data word
   // already stands at the edge where waitrequest is seen low. Writes land
   // at that accepting edge itself, the only edge the master commits to.
   assign rd_take  = avs_read_in && !ack;
   assign wr_take  = avs_write_in && ack;

   // The command word shares its offset with a status mirror; lane 0 set
   // makes it a plain data write, lane 1 with lane 0 clear makes it a command.
   assign flag_wr  = wr_take && flag_hit && avs_byteenable_in[0];
   assign cmd_wr   = wr_take && cmd_hit && avs_byteenable_in[1] && !avs_byteenable_in[0];
   assign opa_wr   = wr_take && opa_hit && avs_byteenable_in[0];
   assign arith_op = (op == psr_pkg::PSR_OP_ADD) || sub_mode;

   // One wait cycle per access. The ack flop lowers waitrequest for one
   // cycle and then clears, so back-to-back requests each get a fresh
   // wait state and a held request is never taken twice.
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in)
         ack <= 1'b0;
      else
         ack <= (avs_read_in || avs_write_in) && !ack;
   end
   assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack;

   // No error path: unmapped reads return zero and unmapped writes vanish
   assign avs_response_out    = 2'b00;

   // Event pins come from other logic domains; two stages before use.
   // Only the second stage reads the first, so a metastable first flop
   // can never reach the status bits directly.
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         ev_meta <= 3'b000;
         ev_sync <= 3'b000;
      end else begin
         ev_meta <= {wdt_clear_in, sleep_exec_in, wdt_timeout_in};
         ev_sync <= ev_meta;
      end
   end

   // Named views of the synchronised events
   assign ev_timeout = ev_sync[0];
   assign ev_sleep   = ev_sync[1];
   assign ev_kick    = ev_sync[2];

   // Subtraction as addition of two's complement. The inverted operand
   // plus a carry-in of one leaves carry set when no borrow occurred.
   assign sub_mode = (op == psr_pkg::PSR_OP_SUB);
   assign b_op     = sub_mode ? (~status) : status;
   assign sum      = {1'b0, operand_a} + {1'b0, b_op} + {8'h00, sub_mode};

   // Nibble sum from the same inputs, so digit borrow has carry's polarity
   assign nib      = {1'b0, operand_a[3:0]} + {1'b0, b_op[3:0]} + {4'h0, sub_mode};

   // Value a command leaves in the register, before events are merged in
   always_comb begin
      cmd_status = status;
      unique case (op)
         psr_pkg::PSR_OP_MOVE: begin
            // Plain move: data lands everywhere except cause bits
            cmd_status = merge_keep(status, wr_byte, `PSR_CAUSE_MASK);
         end
         psr_pkg::PSR_OP_CLEAR: begin
            // Carries are not touched because a clear never updates them
            cmd_status[`PSR_BIT_IBANK]    = 1'b0;
            cmd_status[`PSR_BIT_DBANK_HI] = 1'b0;
            cmd_status[`PSR_BIT_DBANK_LO] = 1'b0;
            cmd_status[`PSR_BIT_Z]        = 1'b1;
         end
         psr_pkg::PSR_OP_ADD, psr_pkg::PSR_OP_SUB: begin
            // Result byte masked off the flag bits; flags come from the sum
            cmd_status = merge_keep(status, sum[7:0],
                                    `PSR_CAUSE_MASK | `PSR_FLAG_MASK);
            cmd_status[`PSR_BIT_C]      = sum[8];
            cmd_status[`PSR_BIT_NCARRY] = nib[4];
            cmd_status[`PSR_BIT_Z]      = (sum[7:0] == 8'h00);
         end
         psr_pkg::PSR_OP_LOGIC: begin
            // Logic ops set only the zero flag; both carries keep their value
            cmd_status = merge_keep(status, wr_byte,
                                    `PSR_CAUSE_MASK | `PSR_FLAG_MASK);
            cmd_status[`PSR_BIT_Z] = (wr_byte == 8'h00);
         end
         default: begin
            // Undefined op codes leave the register as it is
            cmd_status = status;
         end
      endcase
   end

   // Next value: a data write, else a command, then core events on top.
   // Events are applied last so that, should software and the watchdog
   // or sleep logic meet in one cycle, the cause bits follow the event.
   always_comb begin
      next_status = status;
      if (flag_wr) begin
         next_status = merge_keep(status, wr_byte, `PSR_CAUSE_MASK);
      end else if (cmd_wr) begin
         next_status = cmd_status;
      end
      // Cause bits are owned by watchdog and sleep logic only
      if (ev_kick) begin
         next_status[`PSR_BIT_WDOG]  = 1'b1;
         next_status[`PSR_BIT_SLEEP] = 1'b1;
      end
      if (ev_sleep) begin
         next_status[`PSR_BIT_WDOG]  = 1'b1;
         next_status[`PSR_BIT_SLEEP] = 1'b0;
      end
      if (ev_timeout) begin
         next_status[`PSR_BIT_WDOG]  = 1'b0;
      end
   end

   // Status register itself; the low flags have no defined power-on value,
   // so they start at zero and software must not rely on them
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in)
         status <= `PSR_RESET_VAL;
      else
         status <= next_status;
   end

   // Operand for arithmetic commands
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in)
         operand_a <= 8'h00;
      else if (opa_wr)
         operand_a <= wr_byte;
   end

   // Last arithmetic result, visible for checking subtraction.
   // Kept apart from the status byte, whose flag bits mask the result.
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in)
         alu_result <= 8'h00;
      else if (cmd_wr && arith_op)
         alu_result <= sum[7:0];
   end

   // Read data registered; unmapped words read zero.
   // The word stands until the next read is taken.
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         avs_readdata_out <= 32'h0000_0000;
      end else if (rd_take) begin
         if (flag_hit || word_is(avs_address_in, `PSR_OFF_FLAGS))
            avs_readdata_out <= {24'h00_0000, status};
         else if (opa_hit)
            avs_readdata_out <= {24'h00_0000, operand_a};
         else if (word_is(avs_address_in, `PSR_OFF_ALU))
            avs_readdata_out <= {24'h00_0000, alu_result};
         else if (word_is(avs_address_in, `PSR_OFF_EVT))
            avs_readdata_out <= {29'h0000_0000, ev_sync};
         else
            avs_readdata_out <= 32'h0000_0000;
      end
   end

   // Bank selects feed the data-memory decode. Each line is its own flop,
   // loaded from the next value so the decode follows a write with no lag.
   for (genvar i = 0; i < 3; i++) begin : g_bank
      always_ff @(posedge ref_clk_in) begin
         if (!resetn_in)
            bank_bit[i] <= 1'b0;
         else
            bank_bit[i] <= next_status[`PSR_BIT_DBANK_LO + i];
      end
   end

   // Direct addressing picks one of four banks, indirect one of two halves
   assign direct_bank_out   = {bank_bit[1], bank_bit[0]};
   assign indirect_half_out = bank_bit[2];
endmodule // psr_status_reg

//--- test/psr_status_reg_monitor.sv
`timescale 1ns/10ps
module psr_chk (
   // Clock, reset and bus
   input wire logic        ref_clk_in,
   input wire logic        resetn_in,
   input wire logic [10:0] avs_address_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0]  avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic        avs_waitrequest_out,
   input wire logic [1:0]  avs_response_out,
   // Core events and bank selects
   input wire logic        wdt_timeout_in,
   input wire logic        sleep_exec_in,
   input wire logic        wdt_clear_in,
   input wire logic [1:0]  direct_bank_out,
   input wire logic        indirect_half_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);
   // Completed transfers; the status word answers at any mirror
   wire req = avs_read_in | avs_write_in;
   wire ack = req & ~avs_waitrequest_out;
   wire st  = avs_address_in[8:0] == 9'h00c;
   wire rda = ack & avs_read_in & st;
   wire wra = ack & avs_write_in & st & avs_byteenable_in[0];
   wire clr = ack & avs_write_in & (avs_address_in == 11'h40c)
              & (avs_byteenable_in[1:0] == 2'b10) & (avs_writedata_in[10:8] == 3'h1);
   wire ev  = wdt_timeout_in | sleep_exec_in | wdt_clear_in;
   logic [2:0] wd;
   logic [1:0] cause;
   logic       evs;
   // Cause bits only move after a core event, so remember the last value read
   always_ff @(posedge ref_clk_in) begin
      wd <= wra ? avs_writedata_in[7:5] : wd;
      cause <= !resetn_in ? 2'b11 : (rda ? avs_readdata_out[4:3] : cause);
      evs <= resetn_in & (rda ? ev : (evs | ev));
   end
   wait_one_a: assert property ($rose(req) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
      else $error("wait state not one cycle");
   idle_a: assert property (!req |-> !avs_waitrequest_out)
      else $error("waitrequest while idle");
   resp_a: assert property (ack |-> avs_response_out == 2'b00)
      else $error("bad response code");
   bank_wr_a: assert property (wra && avs_address_in[10:9] == 2'b00 |-> ##[1:3] {indirect_half_out, direct_bank_out} == wd)
      else $error("bank select not updated");
   mirror_wr_a: assert property (wra && avs_address_in[10:9] != 2'b00 |-> ##[1:3] {indirect_half_out, direct_bank_out} == wd)
      else $error("mirror write lost");
   clear_a: assert property (clr |-> ##[1:3] {indirect_half_out, direct_bank_out} == 3'h0)
      else $error("clear kept bank bits");
   rd_bank_a: assert property (rda |-> avs_readdata_out[31:5] == {24'h0, indirect_half_out, direct_bank_out})
      else $error("readback differs from bank outputs");
   cause_a: assert property (rda && !evs |-> avs_readdata_out[4:3] == cause)
      else $error("cause bits moved without event");
endmodule // psr_chk
bind psr_status_reg psr_chk u_chk (.*);

//--- test/psr_core_model.sv
`timescale 1ns/10ps
module psr_core_model (
   // Clock and event request from the bench
   input  wire logic       ref_clk_in,
   input  wire logic [1:0] kind_in,
   // Events into the status block
   output logic            wdt_timeout_out,
   output logic            sleep_exec_out,
   output logic            wdt_clear_out
);
   logic [2:0] hold = 3'h0;
   logic [1:0] kind = 2'h0;
   // Event stands four cycles, long enough to pass the block's two-flop sync
   always_ff @(posedge ref_clk_in) begin
      hold <= (kind_in != 2'h0) ? 3'h4 : hold - {2'h0, hold != 3'h0};
      kind <= (kind_in != 2'h0) ? kind_in : kind;
   end
   // One event at a time, so precedence inside the block never decides
   assign wdt_timeout_out = hold != 3'h0 && kind == 2'h1;
   assign sleep_exec_out  = hold != 3'h0 && kind == 2'h2;
   assign wdt_clear_out   = hold != 3'h0 && kind == 2'h3;
endmodule // psr_core_model

//--- test/testbench.sv
`timescale 1ns/10ps
module testbench;
   logic        ref_clk_in = 1'b0;
   logic        resetn_in = 1'b0;
   logic [10:0] avs_address_in = 11'h000;
   logic        avs_read_in = 1'b0;
   logic        avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0;
   logic [3:0]  avs_byteenable_in = 4'h0;
   logic [31:0] avs_readdata_out;
   logic        avs_waitrequest_out;
   logic [1:0]  avs_response_out;
   logic        wdt_timeout_in;
   logic        sleep_exec_in;
   logic        wdt_clear_in;
   logic [1:0]  direct_bank_out;
   logic        indirect_half_out;
   logic [1:0]  kind = 2'h0;
   logic [31:0] q;
   int          miscompares = 0;
   int          num_checks = 0;
   // Operand, op code, result, status after
   logic [31:0] tbl [4] = '{32'h1803001f, 32'h1703f8f8, 32'h0f02071b, 32'hf0020b19};
   psr_status_reg dut (.*);
   psr_core_model u_core (.ref_clk_in, .kind_in(kind), .wdt_timeout_out(wdt_timeout_in),
                          .sleep_exec_out(sleep_exec_in), .wdt_clear_out(wdt_clear_in));
   initial forever #25 ref_clk_in = ~ref_clk_in;
   // Verdict and end of run
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One transfer held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [10:0] a, input logic [31:0] d,
                      input logic [3:0] b);
      int n = 0;
      @(posedge ref_clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_byteenable_in <= b;
      avs_write_in <= w;
      avs_read_in <= !w;
      do begin
         @(posedge ref_clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 50);
      q = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      if (n >= 50) begin
         miscompares++;
         stop_test();
      end
   endtask
   task automatic w8(input logic [10:0] a, input logic [31:0] d, input logic [3:0] b);
      bus(1'b1, a, d, b);
   endtask
   task automatic r8(input logic [10:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'h1);
      chk(q, e);
   endtask
   // Fixed settle time covers the event pulse plus the block's sync stages
   task automatic ev(input logic [1:0] k);
      @(posedge ref_clk_in);
      kind <= k;
      @(posedge ref_clk_in);
      kind <= 2'h0;
      repeat (12) @(posedge ref_clk_in);
   endtask
   // Main sequence
   initial begin
      repeat (10) @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      r8(11'h00c, 32'h18);
      w8(11'h00c, 32'hff, 4'h1);
      r8(11'h20c, 32'hff);
      w8(11'h60c, 32'ha5, 4'h1);
      r8(11'h40c, 32'hbd);
      chk({29'h0, indirect_half_out, direct_bank_out}, 32'h5);
      r8(11'h7fc, 32'h0);
      w8(11'h40c, 32'h100, 4'h2);
      r8(11'h00c, 32'h1d);
      w8(11'h00c, 32'h0, 4'h1);
      for (int i = 0; i < 4; i++) begin
         w8(11'h410, {24'h0, tbl[i][31:24]}, 4'h1);
         w8(11'h40c, {21'h0, tbl[i][18:16], 8'h0}, 4'h2);
         r8(11'h414, {24'h0, tbl[i][15:8]});
         r8(11'h00c, {24'h0, tbl[i][7:0]});
      end
      ev(2'h2);
      r8(11'h00c, 32'h11);
      ev(2'h1);
      r8(11'h00c, 32'h01);
      w8(11'h00c, 32'hff, 4'h1);
      r8(11'h00c, 32'he7);
      ev(2'h3);
      r8(11'h00c, 32'hff);
      stop_test();
   end
endmodule // testbench
